/* File: design/geq_eq_ctrl.sv */
// Gen3 equalization phase tracker with preset to coefficient mapping
`timescale 1ns/10ps
`default_nettype none
module geq_eq_ctrl
  import geq_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Role and link state
  input  wire logic             is_upstream,
  input  wire logic             in_rcvr_config,
  input  wire logic             speed_exit,
  input  wire logic [1:0]       cur_rate,
  input  wire logic [2:0]       link_width,
  // Received training sets
  input  wire logic             rx_ts_valid,
  input  wire logic [1:0]       rx_ts_ec,
  input  wire logic [3:0]       rx_ts_preset,
  input  wire logic             rx_ber_ok,
  input  wire logic             all_lanes_ec01,
  // Local settings and phase completion
  input  wire logic [3:0]       start_preset,
  input  wire logic             phase_done,
  // Transmit side
  output logic [BUS_W-1:0]      tx_cursor_coeff_bus,
  output logic [3:0]            tx_preset,
  output logic [1:0]            tx_ec,
  output logic                  tx_eqts2,
  output logic [5:0]            adv_fs,
  output logic [5:0]            adv_lf,
  // Status
  output logic                  eq_active,
  output logic [1:0]            eq_phase,
  output logic                  eq_done,
  output logic [3:0]            master_lane
);

  logic       rst_s1_q;
  logic       rst_s2_q;
  geq_regs_t  r_q;
  geq_regs_t  r_d;
  logic [BUS_W-1:0] rx_map;
  logic             rx_known;
  logic [BUS_W-1:0] st_map;
  logic             st_known;

  // Reset release is synchronised; assertion remains asynchronous
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  geq_preset_map u_rx_map (
    .preset (rx_ts_preset),
    .coeff  (rx_map),
    .known  (rx_known)
  );

  geq_preset_map u_start_map (
    .preset (start_preset),
    .coeff  (st_map),
    .known  (st_known)
  );

  always_comb begin
    r_d         = r_q;
    r_d.eq_done = 1'b0;
    r_d.fs      = FS_DEFAULT;
    r_d.lf      = LF_DEFAULT;
    // Only steers placement software; no channel choice happens here
    if (link_width == WIDTH_X1) begin
      r_d.master_lane = MASTER_X1;
    end else if (link_width == WIDTH_X2) begin
      r_d.master_lane = MASTER_X2;
    end else if (link_width == WIDTH_X4) begin
      r_d.master_lane = MASTER_X4;
    end else if (link_width == WIDTH_X8) begin
      r_d.master_lane = MASTER_X8;
    end else begin
      r_d.master_lane = MASTER_X16;
    end

    case (r_q.state)
      ST_IDLE: begin
        r_d.eq_active = 1'b0;
        r_d.tx_ec     = EC_IDLE;
        r_d.tx_eqts2  = 1'b0;
        r_d.ts_count  = 4'h0;
        // EQ TS2 only makes sense below 8 GT/s
        if (is_upstream && in_rcvr_config && cur_rate != RATE_8G) begin
          r_d.state     = ST_PH0;
          r_d.phase     = 2'h0;
          r_d.eq_active = 1'b1;
          r_d.tx_eqts2  = 1'b1;
          r_d.preset    = start_preset;
        end else if (!is_upstream && speed_exit && cur_rate == RATE_8G) begin
          r_d.state     = ST_PH0;
          r_d.phase     = 2'h0;
          r_d.eq_active = 1'b1;
        end
      end
      ST_PH0: begin
        if (is_upstream) begin
          r_d.preset = start_preset;
          // Rate change to 8 GT/s takes the upstream port straight to phase 1
          if (cur_rate == RATE_8G) begin
            r_d.state    = ST_PH1;
            r_d.phase    = 2'h1;
            r_d.tx_eqts2 = 1'b0;
            r_d.tx_ec    = EC_PH1;
          end
        end else begin
          if (rx_ts_valid && rx_known) begin
            r_d.coeff  = rx_map;
            r_d.preset = rx_ts_preset;
          end
          // Any bad set or poor error ratio restarts the consecutive count
          if (!rx_ber_ok) begin
            r_d.ts_count = 4'h0;
          end else if (rx_ts_valid) begin
            if (rx_ts_ec == EC_PH1) begin
              r_d.ts_count = r_q.ts_count + 4'h1;
            end else begin
              r_d.ts_count = 4'h0;
            end
          end
          if (rx_ber_ok && rx_ts_valid && rx_ts_ec == EC_PH1
              && r_q.ts_count == TS_CONSEC - 4'h1) begin
            r_d.state    = ST_PH1;
            r_d.phase    = 2'h1;
            r_d.tx_ec    = EC_PH1;
            r_d.ts_count = 4'h0;
          end
        end
      end
      ST_PH1: begin
        if (is_upstream) begin
          if (all_lanes_ec01 && rx_ber_ok) begin
            r_d.state = ST_PH2;
            r_d.phase = 2'h2;
            r_d.tx_ec = EC_PH2;
            if (st_known) begin
              r_d.coeff = st_map;
            end
          end
        end else if (rx_ts_valid && rx_ts_ec == EC_PH2) begin
          r_d.state = ST_PH2;
          r_d.phase = 2'h2;
          r_d.tx_ec = EC_PH2;
        end
      end
      ST_PH2: begin
        // Tuning may be empty, but the phase is still walked through
        if (phase_done) begin
          r_d.state = ST_PH3;
          r_d.phase = 2'h3;
          r_d.tx_ec = EC_PH3;
        end
      end
      ST_PH3: begin
        if (phase_done) begin
          r_d.state     = ST_IDLE;
          r_d.phase     = 2'h0;
          r_d.tx_ec     = EC_IDLE;
          r_d.eq_active = 1'b0;
          r_d.eq_done   = 1'b1;
        end
      end
      default: begin
        r_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      r_q <= '{state: ST_IDLE, phase: 2'h0, eq_active: 1'b0, ts_count: 4'h0,
               coeff: COEFF_RST, preset: PRESET_RST, tx_ec: EC_IDLE,
               tx_eqts2: 1'b0, eq_done: 1'b0, fs: FS_DEFAULT,
               lf: LF_DEFAULT, master_lane: MASTER_X1};
    end else begin
      r_q <= r_d;
    end
  end

  assign tx_cursor_coeff_bus = r_q.coeff;
  assign tx_preset           = r_q.preset;
  assign tx_ec               = r_q.tx_ec;
  assign tx_eqts2            = r_q.tx_eqts2;
  assign adv_fs              = r_q.fs;
  assign adv_lf              = r_q.lf;
  assign eq_active           = r_q.eq_active;
  assign eq_phase            = r_q.phase;
  assign eq_done             = r_q.eq_done;
  assign master_lane         = r_q.master_lane;

endmodule : geq_eq_ctrl
`default_nettype wire

/* File: design/geq_pkg.sv */
// Shared constants and types for the Gen3 equalization block
package geq_pkg;

  // Coefficient bus layout: pre-cursor low, main cursor mid, post-cursor high
  localparam int unsigned COEFF_W      = 6;
  localparam int unsigned BUS_W        = 18;
  localparam int unsigned PRE_LSB      = 0;
  localparam int unsigned MAIN_LSB     = 6;
  localparam int unsigned POST_LSB     = 12;

  // Preset codes, per preset: post, main, pre
  localparam logic [5:0] P1_POST  = 6'h0f;
  localparam logic [5:0] P1_MAIN  = 6'h2d;
  localparam logic [5:0] P1_PRE   = 6'h00;
  localparam logic [5:0] P2_POST  = 6'h0a;
  localparam logic [5:0] P2_MAIN  = 6'h32;
  localparam logic [5:0] P2_PRE   = 6'h00;
  localparam logic [5:0] P3_POST  = 6'h0c;
  localparam logic [5:0] P3_MAIN  = 6'h30;
  localparam logic [5:0] P3_PRE   = 6'h00;
  localparam logic [5:0] P4_POST  = 6'h08;
  localparam logic [5:0] P4_MAIN  = 6'h34;
  localparam logic [5:0] P4_PRE   = 6'h00;
  localparam logic [5:0] P5_POST  = 6'h00;
  localparam logic [5:0] P5_MAIN  = 6'h3c;
  localparam logic [5:0] P5_PRE   = 6'h00;
  localparam logic [5:0] P6_POST  = 6'h00;
  localparam logic [5:0] P6_MAIN  = 6'h36;
  localparam logic [5:0] P6_PRE   = 6'h06;
  localparam logic [5:0] P7_POST  = 6'h00;
  localparam logic [5:0] P7_MAIN  = 6'h34;
  localparam logic [5:0] P7_PRE   = 6'h08;
  localparam logic [5:0] P8_POST  = 6'h0c;
  localparam logic [5:0] P8_MAIN  = 6'h2a;
  localparam logic [5:0] P8_PRE   = 6'h06;
  localparam logic [5:0] P9_POST  = 6'h08;
  localparam logic [5:0] P9_MAIN  = 6'h2c;
  localparam logic [5:0] P9_PRE   = 6'h08;
  localparam logic [5:0] P10_POST = 6'h00;
  localparam logic [5:0] P10_MAIN = 6'h32;
  localparam logic [5:0] P10_PRE  = 6'h0a;
  localparam logic [5:0] P11_POST = 6'h16;
  localparam logic [5:0] P11_MAIN = 6'h26;
  localparam logic [5:0] P11_PRE  = 6'h00;

  // Equalization control field values
  localparam logic [1:0] EC_IDLE   = 2'h0;
  localparam logic [1:0] EC_PH1    = 2'h1;
  localparam logic [1:0] EC_PH2    = 2'h2;
  localparam logic [1:0] EC_PH3    = 2'h3;

  // Link rate encoding
  localparam logic [1:0] RATE_2G5  = 2'h0;
  localparam logic [1:0] RATE_5G   = 2'h1;
  localparam logic [1:0] RATE_8G   = 2'h2;

  // Advertised full swing and low frequency
  localparam logic [5:0] FS_DEFAULT = 6'h28;
  localparam logic [5:0] LF_DEFAULT = 6'h0d;

  // Consecutive good training sets needed before leaving phase 0
  localparam logic [3:0] TS_CONSEC  = 4'h8;

  // Reset values
  localparam logic [BUS_W-1:0] COEFF_RST  = 18'h00000;
  localparam logic [3:0]       PRESET_RST = 4'h0;

  // Link width encoding and default coding-layer master lane
  localparam logic [2:0] WIDTH_X1  = 3'h0;
  localparam logic [2:0] WIDTH_X2  = 3'h1;
  localparam logic [2:0] WIDTH_X4  = 3'h2;
  localparam logic [2:0] WIDTH_X8  = 3'h3;
  localparam logic [2:0] WIDTH_X16 = 3'h4;
  localparam logic [3:0] MASTER_X1  = 4'h1;
  localparam logic [3:0] MASTER_X2  = 4'h1;
  localparam logic [3:0] MASTER_X4  = 4'h2;
  localparam logic [3:0] MASTER_X8  = 4'h4;
  localparam logic [3:0] MASTER_X16 = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PH0,
    ST_PH1,
    ST_PH2,
    ST_PH3
  } geq_state_t;

  typedef struct packed {
    geq_state_t       state;
    logic [1:0]       phase;
    logic             eq_active;
    logic [3:0]       ts_count;
    logic [BUS_W-1:0] coeff;
    logic [3:0]       preset;
    logic [1:0]       tx_ec;
    logic             tx_eqts2;
    logic             eq_done;
    logic [5:0]       fs;
    logic [5:0]       lf;
    logic [3:0]       master_lane;
  } geq_regs_t;

endpackage : geq_pkg

/* File: design/geq_preset_map.sv */
// Preset number to transmit cursor coefficient bus lookup
`timescale 1ns/10ps
`default_nettype none
module geq_preset_map
  import geq_pkg::*;
(
  // Preset in
  input  wire logic [3:0]       preset,
  // Coefficient bus out
  output logic [BUS_W-1:0]      coeff,
  output logic                  known
);

  always_comb begin
    known = 1'b1;
    case (preset)
      4'h1:    coeff = {P1_POST, P1_MAIN, P1_PRE};
      4'h2:    coeff = {P2_POST, P2_MAIN, P2_PRE};
      4'h3:    coeff = {P3_POST, P3_MAIN, P3_PRE};
      4'h4:    coeff = {P4_POST, P4_MAIN, P4_PRE};
      4'h5:    coeff = {P5_POST, P5_MAIN, P5_PRE};
      4'h6:    coeff = {P6_POST, P6_MAIN, P6_PRE};
      4'h7:    coeff = {P7_POST, P7_MAIN, P7_PRE};
      4'h8:    coeff = {P8_POST, P8_MAIN, P8_PRE};
      4'h9:    coeff = {P9_POST, P9_MAIN, P9_PRE};
      4'ha:    coeff = {P10_POST, P10_MAIN, P10_PRE};
      4'hb:    coeff = {P11_POST, P11_MAIN, P11_PRE};
      default: begin
        coeff = COEFF_RST;
        known = 1'b0;
      end
    endcase
  end

endmodule : geq_preset_map
`default_nettype wire

/* File: tb/geq_eq_ctrl_properties.sv */
// Port-level checks on the equalization controller
`timescale 1ns/10ps
`default_nettype none
module geq_eq_ctrl_chk
  import geq_pkg::*;
(
  // Clock, reset and inputs
  input wire logic             mclk,
  input wire logic             rst_b,
  input wire logic             is_upstream,
  input wire logic             in_rcvr_config,
  input wire logic             speed_exit,
  input wire logic [1:0]       cur_rate,
  input wire logic [2:0]       link_width,
  input wire logic             rx_ts_valid,
  input wire logic             rx_ber_ok,
  input wire logic             all_lanes_ec01,
  input wire logic             phase_done,
  // Outputs
  input wire logic [BUS_W-1:0] tx_cursor_coeff_bus,
  input wire logic [1:0]       tx_ec,
  input wire logic             tx_eqts2,
  input wire logic [5:0]       adv_fs,
  input wire logic [5:0]       adv_lf,
  input wire logic             eq_active,
  input wire logic [1:0]       eq_phase,
  input wire logic             eq_done,
  input wire logic [3:0]       master_lane
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_ph0_to_ph1;
    eq_active && eq_phase == 2'h0 ##1 eq_phase == 2'h1;
  endsequence
  sequence s_last_done;
    eq_phase == 2'h3 && phase_done;
  endsequence

  chk_fs_lf_fixed: assert property (adv_fs == 6'h28 && adv_lf == 6'h0d)
    else $error("advertised fs or lf wrong");
  chk_master_x4: assert property (link_width == WIDTH_X4 |=> master_lane == 4'h2)
    else $error("x4 master lane wrong");
  chk_phase_step: assert property ($changed(eq_phase) |-> eq_phase == $past(eq_phase) + 2'h1)
    else $error("phase skipped");
  chk_us_enter: assert property (is_upstream && in_rcvr_config && cur_rate != RATE_8G
    && !eq_active |=> eq_active && eq_phase == 2'h0 && tx_eqts2)
    else $error("upstream phase 0 not entered");
  chk_ds_enter: assert property (!is_upstream && speed_exit && !eq_active
    |=> eq_active == ($past(cur_rate) == RATE_8G))
    else $error("downstream phase 0 entry wrong");
  chk_ph1_ec: assert property (s_ph0_to_ph1 |-> tx_ec == EC_PH1 && !tx_eqts2)
    else $error("phase 1 control field wrong");
  chk_ds_ber_gate: assert property (!is_upstream && eq_phase == 2'h0 && !rx_ber_ok
    |=> eq_phase == 2'h0)
    else $error("phase 1 without good error ratio");
  chk_us_rate8: assert property (is_upstream && eq_active && eq_phase == 2'h0
    && cur_rate == RATE_8G |=> eq_phase == 2'h1)
    else $error("upstream not in phase 1 at 8G");
  chk_us_ph2: assert property (is_upstream && eq_phase == 2'h1 && all_lanes_ec01 && rx_ber_ok
    |=> eq_phase == 2'h2 && tx_ec == EC_PH2)
    else $error("upstream phase 2 entry wrong");
  chk_done_pulse: assert property (s_last_done |=> eq_done && !eq_active ##1 !eq_done)
    else $error("done pulse wrong");
  chk_coeff_hold: assert property ($changed(tx_cursor_coeff_bus)
    |-> $past(rx_ts_valid) || $changed(eq_phase))
    else $error("coefficient bus moved without update");
endmodule : geq_eq_ctrl_chk

bind geq_eq_ctrl geq_eq_ctrl_chk i_geq_eq_ctrl_chk (
  .mclk                (mclk),
  .rst_b               (rst_b),
  .is_upstream         (is_upstream),
  .in_rcvr_config      (in_rcvr_config),
  .speed_exit          (speed_exit),
  .cur_rate            (cur_rate),
  .link_width          (link_width),
  .rx_ts_valid         (rx_ts_valid),
  .rx_ber_ok           (rx_ber_ok),
  .all_lanes_ec01      (all_lanes_ec01),
  .phase_done          (phase_done),
  .tx_cursor_coeff_bus (tx_cursor_coeff_bus),
  .tx_ec               (tx_ec),
  .tx_eqts2            (tx_eqts2),
  .adv_fs              (adv_fs),
  .adv_lf              (adv_lf),
  .eq_active           (eq_active),
  .eq_phase            (eq_phase),
  .eq_done             (eq_done),
  .master_lane         (master_lane)
);
`default_nettype wire

/* File: tb/geq_mac_model.sv */
// Link controller model that feeds received training sets to the block
`timescale 1ns/10ps
`default_nettype none
module geq_mac_model (
  // Clock
  input  wire logic       mclk,
  // Received training sets
  output var  logic       rx_ts_valid,
  output var  logic [1:0] rx_ts_ec,
  output var  logic [3:0] rx_ts_preset
);
  initial begin
    rx_ts_valid  = 1'b0;
    rx_ts_ec     = 2'h3;
    rx_ts_preset = 4'hf;
  end

  // Fields flip once the set has gone, so a stale value can never match by luck
  task automatic send_ts(input logic [1:0] ec, input logic [3:0] pr);
    rx_ts_valid  = 1'b1;
    rx_ts_ec     = ec;
    rx_ts_preset = pr;
    @(posedge mclk);
    #1;
    rx_ts_valid  = 1'b0;
    rx_ts_ec     = ~ec;
    rx_ts_preset = ~pr;
    @(posedge mclk);
    #1;
  endtask : send_ts
endmodule : geq_mac_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the equalization controller
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import geq_pkg::*;
;
  logic             mclk, rst_b, is_upstream, in_rcvr_config, speed_exit, tx_eqts2;
  logic             rx_ts_valid, rx_ber_ok, all_lanes_ec01, phase_done, eq_active, eq_done;
  logic [1:0]       cur_rate, rx_ts_ec, tx_ec, eq_phase;
  logic [2:0]       link_width;
  logic [3:0]       rx_ts_preset, start_preset, tx_preset, master_lane;
  logic [5:0]       adv_fs, adv_lf;
  logic [BUS_W-1:0] tx_cursor_coeff_bus;
  int               errors, samples_checked, seed, sp, e_cf;
  int               map [16];

  geq_eq_ctrl i_geq_eq_ctrl (
    .mclk                (mclk),
    .rst_b               (rst_b),
    .is_upstream         (is_upstream),
    .in_rcvr_config      (in_rcvr_config),
    .speed_exit          (speed_exit),
    .cur_rate            (cur_rate),
    .link_width          (link_width),
    .rx_ts_valid         (rx_ts_valid),
    .rx_ts_ec            (rx_ts_ec),
    .rx_ts_preset        (rx_ts_preset),
    .rx_ber_ok           (rx_ber_ok),
    .all_lanes_ec01      (all_lanes_ec01),
    .start_preset        (start_preset),
    .phase_done          (phase_done),
    .tx_cursor_coeff_bus (tx_cursor_coeff_bus),
    .tx_preset           (tx_preset),
    .tx_ec               (tx_ec),
    .tx_eqts2            (tx_eqts2),
    .adv_fs              (adv_fs),
    .adv_lf              (adv_lf),
    .eq_active           (eq_active),
    .eq_phase            (eq_phase),
    .eq_done             (eq_done),
    .master_lane         (master_lane)
  );

  geq_mac_model i_geq_mac_model (
    .mclk         (mclk),
    .rx_ts_valid  (rx_ts_valid),
    .rx_ts_ec     (rx_ts_ec),
    .rx_ts_preset (rx_ts_preset)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic fail(input string m);
    errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail

  task automatic expect_st(input int ph, input int act, input int ec);
    samples_checked++;
    if (tx_cursor_coeff_bus !== e_cf[17:0] || eq_phase !== ph[1:0] || eq_active !== act[0]
        || tx_ec !== ec[1:0] || adv_fs !== 6'h28 || adv_lf !== 6'h0d)
      fail("state or coefficients differ from model");
  endtask : expect_st

  task automatic finish_eq();
    phase_done = 1'b1;
    step();
    expect_st(3, 1, 3);
    step();
    phase_done = 1'b0;
    expect_st(0, 0, 0);
    if (eq_done !== 1'b1)
      fail("done pulse missing");
    step();
    if (eq_done !== 1'b0)
      fail("done pulse too long");
  endtask : finish_eq

  task automatic give_verdict();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    #20000;
    fail("watchdog expired");
    give_verdict();
  end

  initial begin
    seed = 9252;
    {rst_b, is_upstream, in_rcvr_config, speed_exit, rx_ber_ok, all_lanes_ec01, phase_done} = '0;
    cur_rate = RATE_2G5;
    link_width = WIDTH_X1;
    start_preset = 4'h1;
    e_cf = 0;
    map = '{18'h0, 18'h0fb40, 18'h0ac80, 18'h0cc00, 18'h08d00, 18'h00f00, 18'h00d86,
            18'h00d08, 18'h0ca86, 18'h08b08, 18'h00c8a, 18'h16980, 18'h0, 18'h0, 18'h0, 18'h0};
    step(5);
    rst_b = 1'b1;
    step(3);
    expect_st(0, 0, 0);
    for (int w = 0; w < 6; w++) begin
      link_width = (w == 5) ? 3'h7 : w[2:0];
      step(2);
      samples_checked++;
      if (master_lane !== ((w < 2) ? 4'h1 : (w == 2) ? 4'h2 : (w == 3) ? 4'h4 : 4'h8))
        fail("master lane wrong");
    end
    // Downstream: speed exit only counts at 8G
    for (int r = 0; r < 3; r++) begin
      cur_rate = r[1:0];
      speed_exit = 1'b1;
      step();
      speed_exit = 1'b0;
      expect_st(0, r == 2, 0);
    end
    rx_ber_ok = 1'b1;
    for (int p = 0; p < 16; p++) begin
      sp = (p < 12) ? p : $unsigned($random(seed)) % 16;
      if (map[sp] != 0)
        e_cf = map[sp];
      i_geq_mac_model.send_ts(EC_IDLE, sp[3:0]);
      expect_st(0, 1, 0);
      if (map[sp] != 0 && tx_preset !== sp[3:0])
        fail("received preset not applied");
    end
    // Eight good sets in a row, with a bad error ratio breaking the first run
    for (int i = 0; i < 16; i++) begin
      rx_ber_ok = (i != 7);
      i_geq_mac_model.send_ts(EC_PH1, 4'h0);
      expect_st(i == 15, 1, i == 15);
    end
    i_geq_mac_model.send_ts(EC_PH2, 4'h0);
    expect_st(2, 1, 2);
    finish_eq();
    is_upstream = 1'b1;
    // RcvrConfig while already at 8G must not start phase 0
    in_rcvr_config = 1'b1;
    step();
    expect_st(0, 0, 0);
    if (tx_eqts2 !== 1'b0)
      fail("training sets sent at 8G");
    for (int r = 0; r < 2; r++) begin
      sp = 1 + $unsigned($random(seed)) % 11;
      start_preset = sp[3:0];
      cur_rate = r[1:0];
      in_rcvr_config = 1'b1;
      step();
      in_rcvr_config = 1'b0;
      expect_st(0, 1, 0);
      if (tx_eqts2 !== 1'b1 || tx_preset !== sp[3:0])
        fail("starting presets not sent");
      cur_rate = RATE_8G;
      step();
      expect_st(1, 1, 1);
      all_lanes_ec01 = 1'b1;
      step();
      all_lanes_ec01 = 1'b0;
      e_cf = map[sp];
      expect_st(2, 1, 2);
      finish_eq();
    end
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
